// [rtl/wrs_device.sv]
// receiver supervisor: current limit, rectifier, sense pin, shutdown
// Behaviour
// - below 300 mA use fixed 400 mA limit
// - above 300 mA limit tracks current plus 50
// - limit applies only while packet is sent
// - rectifier diode-only during start-up
// - half-sync once rectified voltage passes lockout
// - full-sync until current below exit threshold
// - sense compared against hot and cold thresholds
// - bias strobe 24 ms, deglitched comparator sampling
// - then pin floats, monitored 35 or 235 ms
// - high pin while floating decodes control one
// - host idles done high, fault low
// - pin pulled low: shutdown, fault indicated
// - pin pulled high: shutdown, charge complete
// - host never drives done low fault high
// - die over-temperature stops regulator, sends fault
// - resume after temperature falls by hysteresis
// - termination sent as header 0x02 plus reason
`timescale 1ns/10ps
module wrs_device #(
	parameter int BIAS_CYCLES = wrs_pkg::BIAS_CYC,
	parameter int PRIO_CYCLES = wrs_pkg::PRIO_CYC,
	parameter int STD_CYCLES = wrs_pkg::STD_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	wrs_pin_if.device pin,
	input wire logic [wrs_pkg::CUR_W-1:0] out_current_in,
	input wire logic meas_valid_in,
	input wire logic packet_active_in,
	input wire logic priority_period_in,
	input wire logic above_uvlo_in,
	input wire logic [wrs_pkg::CUR_W-1:0] full_sync_entry_current_in,
	input wire logic [wrs_pkg::CUR_W-1:0] full_sync_exit_current_in,
	input wire logic die_at_shutdown_in,
	input wire logic die_below_hyst_in,
	input wire logic ept_ready_in,
	output logic [wrs_pkg::CUR_W-1:0] current_limit_out,
	output logic limit_active_out,
	output logic tracking_mode_out,
	output logic [1:0] rect_mode_out,
	output logic regulator_en_out,
	output logic sense_read_strobe_out,
	output logic sense_hot_out,
	output logic sense_cold_out,
	output logic ctrl_one_out,
	output logic fault_ind_out,
	output logic charge_done_out,
	output logic ept_valid_out,
	output logic [7:0] ept_header_out,
	output logic [7:0] ept_reason_out
);
	import wrs_pkg::*;

	// refuse phase lengths and a deglitch count the counters cannot serve
	if (BIAS_CYCLES < 1 || PRIO_CYCLES < 1 || STD_CYCLES < 1) begin : g_bad_len
		$error("phase lengths must be at least one cycle");
	end
	if (DEGLITCH_CYC >= BIAS_CYCLES || DEGLITCH_CYC > 31) begin : g_bad_dg
		$error("deglitch must fit within bias phase and its counter");
	end

	// synchronisers for analog comparator inputs
	logic [5:0] s1_ff, s2_ff;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			s1_ff <= 6'h00;
			s2_ff <= 6'h00;
		end else begin
			s1_ff <= {pin.pin_above_hi, pin.pin_below_lo, pin.pin_hot,
				pin.pin_cold, above_uvlo_in, die_at_shutdown_in};
			s2_ff <= s1_ff;
		end
	end
	wire hi_s = s2_ff[5];
	wire lo_s = s2_ff[4];
	wire hot_s = s2_ff[3];
	wire cold_s = s2_ff[2];
	wire uvlo_s = s2_ff[1];
	wire tsd_s = s2_ff[0];
	logic hys_s1_ff, hys_s2_ff;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			hys_s1_ff <= 1'b0;
			hys_s2_ff <= 1'b0;
		end else begin
			hys_s1_ff <= die_below_hyst_in;
			hys_s2_ff <= hys_s1_ff;
		end
	end

	// communication current limit
	logic track_ff;
	logic [CUR_W-1:0] limit_ff;
	wire nxt_track = out_current_in > FIXED_REGION_MA;
	wire [CUR_W-1:0] track_lim = CUR_W'(out_current_in + TRACK_MARGIN_MA);
	wire [CUR_W-1:0] nxt_limit = nxt_track ? track_lim : FIXED_LIMIT_MA;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			track_ff <= 1'b0;
			limit_ff <= FIXED_LIMIT_MA;
		end else if (meas_valid_in) begin
			track_ff <= nxt_track;
			limit_ff <= nxt_limit;
		end
	end
	assign current_limit_out = limit_ff;
	assign tracking_mode_out = track_ff;
	assign limit_active_out = packet_active_in;

	// rectifier: diode until lockout passed, then one half/full bit
	logic sync_on_ff, full_ff;
	wire go_full = out_current_in > full_sync_entry_current_in;
	wire go_half = out_current_in < full_sync_exit_current_in;
	wire nxt_full = full_ff ? !go_half : go_full;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sync_on_ff <= 1'b0;
			full_ff <= 1'b0;
		end else begin
			if (uvlo_s)
				sync_on_ff <= 1'b1;
			if (sync_on_ff && meas_valid_in)
				full_ff <= nxt_full;
		end
	end
	assign rect_mode_out = !sync_on_ff ? WRS_RECT_DIODE :
		(full_ff ? WRS_RECT_FULL : WRS_RECT_HALF);

	// periodic bias and monitor schedule
	wrs_phase_t phase_ff;
	logic [31:0] cnt_ff;
	logic [31:0] mon_len_ff;
	logic [4:0] dg_ff;
	logic hot_ff, cold_ff;
	wire bias_end = phase_ff == WRS_PH_BIAS && cnt_ff == 32'(BIAS_CYCLES - 1);
	wire mon_end = phase_ff == WRS_PH_MONITOR && cnt_ff == mon_len_ff - 32'h1;
	wire [31:0] mon_len = priority_period_in ? 32'(PRIO_CYCLES) :
		32'(STD_CYCLES);
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			phase_ff <= WRS_PH_BIAS;
			cnt_ff <= 32'h0;
			mon_len_ff <= 32'(STD_CYCLES);
		end else begin
			case (phase_ff)
			WRS_PH_BIAS: begin
				cnt_ff <= bias_end ? 32'h0 : cnt_ff + 32'h1;
				if (bias_end) begin
					phase_ff <= WRS_PH_MONITOR;
					mon_len_ff <= mon_len;
				end
			end
			WRS_PH_MONITOR: begin
				cnt_ff <= mon_end ? 32'h0 : cnt_ff + 32'h1;
				if (mon_end)
					phase_ff <= WRS_PH_BIAS;
			end
			default: begin
				phase_ff <= WRS_PH_BIAS;
				cnt_ff <= 32'h0;
			end
			endcase
		end
	end
	wire in_bias = phase_ff == WRS_PH_BIAS;
	assign sense_read_strobe_out = in_bias;
	assign pin.bias_drive = in_bias;
	assign pin.bias_oe_n = !in_bias;

	// deglitch: comparator state must hold steady before use
	logic [1:0] prev_ff;
	wire steady = {hot_s, cold_s} == prev_ff;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			prev_ff <= 2'b00;
			dg_ff <= 5'h00;
			hot_ff <= 1'b0;
			cold_ff <= 1'b0;
		end else begin
			prev_ff <= {hot_s, cold_s};
			if (!in_bias || !steady)
				dg_ff <= 5'h00;
			else if (dg_ff != 5'(DEGLITCH_CYC))
				dg_ff <= dg_ff + 5'h01;
			if (in_bias && steady && dg_ff == 5'(DEGLITCH_CYC - 1)) begin
				hot_ff <= hot_s;
				cold_ff <= cold_s;
			end
		end
	end
	assign sense_hot_out = hot_ff;
	assign sense_cold_out = cold_ff;

	// host requests, decoded only while pin floats
	wire mon = !in_bias;
	logic ctrl_ff, fault_ff, done_ff, tsd_ff, ept_ff;
	logic [7:0] reason_ff;
	wire ctrl_hit = mon && hi_s;
	wire fault_hit = mon && lo_s;
	wire new_tsd = tsd_s && !tsd_ff;
	wire new_term = (ctrl_hit && !done_ff) || (fault_hit && !fault_ff) ||
		(hot_ff && !ept_ff) || new_tsd;
	wire [7:0] nxt_reason = new_tsd ? EPT_INTERNAL_FAULT :
		(fault_hit || hot_ff) ? EPT_OVERTEMP :
		ctrl_hit ? EPT_CHARGE_DONE : EPT_UNKNOWN;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ctrl_ff <= 1'b0;
			fault_ff <= 1'b0;
			done_ff <= 1'b0;
			tsd_ff <= 1'b0;
			ept_ff <= 1'b0;
			reason_ff <= EPT_UNKNOWN;
		end else begin
			if (mon)
				ctrl_ff <= hi_s;
			if (fault_hit)
				fault_ff <= 1'b1;
			if (ctrl_hit)
				done_ff <= 1'b1;
			if (tsd_s)
				tsd_ff <= 1'b1;
			else if (hys_s2_ff)
				tsd_ff <= 1'b0;
			if (new_term) begin
				ept_ff <= 1'b1;
				reason_ff <= nxt_reason;
			end else if (ept_ff && ept_ready_in) begin
				ept_ff <= 1'b0;
			end
		end
	end
	assign ctrl_one_out = ctrl_ff;
	assign fault_ind_out = fault_ff;
	assign charge_done_out = done_ff;
	assign regulator_en_out = !tsd_ff && !fault_ff && !done_ff;
	assign ept_valid_out = ept_ff;
	assign ept_header_out = EPT_HEADER;
	assign ept_reason_out = reason_ff;
endmodule : wrs_device

// [rtl/wrs_pkg.sv]
// shared constants and types for the wireless receiver supervisor
package wrs_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CUR_W = 12;
	localparam logic [11:0] FIXED_REGION_MA = 12'h12C;
	localparam logic [11:0] FIXED_LIMIT_MA = 12'h190;
	localparam logic [11:0] TRACK_MARGIN_MA = 12'h032;
	localparam int BIAS_MS = 24;
	localparam int PRIO_MS = 35;
	localparam int STD_MS = 235;
	localparam int BIAS_CYC = BIAS_MS * (CLK_HZ / 1000);
	localparam int PRIO_CYC = PRIO_MS * (CLK_HZ / 1000);
	localparam int STD_CYC = STD_MS * (CLK_HZ / 1000);
	localparam int DEGLITCH_CYC = 16;
	localparam logic [7:0] EPT_HEADER = 8'h02;
	localparam logic [7:0] EPT_UNKNOWN = 8'h00;
	localparam logic [7:0] EPT_CHARGE_DONE = 8'h01;
	localparam logic [7:0] EPT_INTERNAL_FAULT = 8'h02;
	localparam logic [7:0] EPT_OVERTEMP = 8'h03;
	typedef enum logic [1:0] {
		WRS_RECT_DIODE = 2'b00,
		WRS_RECT_HALF = 2'b01,
		WRS_RECT_FULL = 2'b10
	} wrs_rect_t;
	typedef enum logic [1:0] {
		WRS_PH_BIAS = 2'b00,
		WRS_PH_MONITOR = 2'b01
	} wrs_phase_t;
endpackage : wrs_pkg

// [rtl/wrs_pin_if.sv]
// shared sense/control pin between receiver and host switches
`timescale 1ns/10ps
interface wrs_pin_if;
	logic done_line;
	logic fault_line;
	logic bias_drive;
	logic bias_oe_n;
	logic pin_above_hi;
	logic pin_below_lo;
	logic pin_hot;
	logic pin_cold;
	modport device(input pin_above_hi, input pin_below_lo, input pin_hot,
		input pin_cold, output bias_drive, output bias_oe_n);
	modport host(output done_line, output fault_line);
endinterface : wrs_pin_if

// [rtl/wrs_host.sv]
// host side: two switch controls for the shared pin
`timescale 1ns/10ps
module wrs_host (
	input wire logic core_clk_in,
	input wire logic rst_in,
	wrs_pin_if.host pin,
	input wire logic req_fault_in,
	input wire logic req_done_in
);
	import wrs_pkg::*;

	logic done_ff, fault_ff;
	// fault wins; never done low with fault high
	wire nxt_fault = req_fault_in;
	wire nxt_done = !(req_done_in && !req_fault_in);
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			done_ff <= 1'b1;
			fault_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
			fault_ff <= nxt_fault;
		end
	end
	assign pin.done_line = done_ff;
	assign pin.fault_line = fault_ff;
endmodule : wrs_host

// [bench/wrs_pin_assertions.sv]
// checker on the shared sense/control pin
`timescale 1ns/10ps
module wrs_pin_assertions #(
	parameter int BIAS_CYCLES = 50,
	parameter int PRIO_CYCLES = 60,
	parameter int STD_CYCLES = 100
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic done_line,
	input wire logic fault_line,
	input wire logic bias_drive,
	input wire logic bias_oe_n
);
	logic ph_ff;
	int len_ff;
	// length of the phase that just ended, read at the phase change
	always_ff @(posedge core_clk_in) begin
		ph_ff <= bias_oe_n;
		len_ff <= (rst_in || bias_oe_n != ph_ff) ? 1 : len_ff + 1;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_bias_end;
		!ph_ff && bias_oe_n;
	endsequence
	sequence s_mon_end;
		ph_ff && !bias_oe_n;
	endsequence
	AST_BIAS_LEN: assert property (s_bias_end |->
		len_ff inside {[BIAS_CYCLES-1:BIAS_CYCLES+2]})
		else $error("bias phase length wrong");
	AST_MON_LEN: assert property (s_mon_end |->
		len_ff inside {[PRIO_CYCLES-1:PRIO_CYCLES+1],
		[STD_CYCLES-1:STD_CYCLES+1]})
		else $error("monitor phase length wrong");
	AST_FLOAT_HOLD: assert property (s_bias_end |=> bias_oe_n [*8])
		else $error("pin driven again too soon");
	AST_BIAS_DRV: assert property (!bias_oe_n |-> bias_drive)
		else $error("bias level missing while driving");
	AST_START_BIAS: assert property ($fell(rst_in) |-> !bias_oe_n)
		else $error("schedule not in bias after reset");
	AST_HOST_IDLE: assert property ($fell(rst_in) |-> done_line && !fault_line)
		else $error("host lines not idle after reset");
	AST_NO_SHORT: assert property (fault_line |-> done_line)
		else $error("both host switches on");
endmodule : wrs_pin_assertions

// [bench/wireless_rx_supervisor_test.sv]
// self-checking bench: receiver and host joined by the pin
`timescale 1ns/10ps
module wireless_rx_supervisor_test;
	import wrs_pkg::*;
	localparam int BC = 50;
	logic clk = 0, rst = 1, mv = 0, pkt = 0, prio = 0, uvlo = 0, rdy = 0;
	logic die_sd = 0, die_hy = 0, rq_f = 0, rq_d = 0, hot = 0, cold = 0;
	logic [11:0] cur = 0, lim;
	logic [11:0] ent = 12'h258, ext = 12'h1F4;
	logic la, trk, ren, strb, s_hot, s_cold, c1, fi, cd, ev;
	logic [1:0] rect;
	logic [7:0] eh, er;
	int n_mismatch = 0, comparisons = 0;
	wrs_pin_if pin();
	assign pin.pin_above_hi = !pin.done_line && !pin.fault_line;
	assign pin.pin_below_lo = pin.fault_line;
	assign pin.pin_hot = hot;
	assign pin.pin_cold = cold;
	wrs_device #(.BIAS_CYCLES(BC), .PRIO_CYCLES(60), .STD_CYCLES(100))
	u_wrs_device (.core_clk_in(clk), .rst_in(rst), .pin(pin),
		.out_current_in(cur), .meas_valid_in(mv), .packet_active_in(pkt),
		.priority_period_in(prio), .above_uvlo_in(uvlo),
		.full_sync_entry_current_in(ent),
		.full_sync_exit_current_in(ext), .die_at_shutdown_in(die_sd),
		.die_below_hyst_in(die_hy), .ept_ready_in(rdy),
		.current_limit_out(lim), .limit_active_out(la),
		.tracking_mode_out(trk), .rect_mode_out(rect),
		.regulator_en_out(ren), .sense_read_strobe_out(strb),
		.sense_hot_out(s_hot), .sense_cold_out(s_cold), .ctrl_one_out(c1),
		.fault_ind_out(fi), .charge_done_out(cd), .ept_valid_out(ev),
		.ept_header_out(eh), .ept_reason_out(er));
	wrs_host u_wrs_host (.core_clk_in(clk), .rst_in(rst), .pin(pin),
		.req_fault_in(rq_f), .req_done_in(rq_d));
	wrs_pin_assertions #(.BIAS_CYCLES(BC), .PRIO_CYCLES(60),
		.STD_CYCLES(100)) u_wrs_pin_assertions (.core_clk_in(clk),
		.rst_in(rst), .done_line(pin.done_line),
		.fault_line(pin.fault_line), .bias_drive(pin.bias_drive),
		.bias_oe_n(pin.bias_oe_n));
	initial begin
		forever #5 clk = ~clk;
	end
	task tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk
	task chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task do_rst;
		rst = 1;
		tk(5);
		rst = 0;
		tk(1);
	endtask : do_rst
	task meas(input logic [11:0] c);
		cur = c;
		mv = 1;
		tk(1);
		mv = 0;
		tk(2);
	endtask : meas
	task ept(input logic [7:0] r);
		for (int i = 0; i < 400 && ev !== 1'b1; i++)
			tk(1);
		chk("ept_valid", ev, 1'b1);
		chk("ept_header", eh, EPT_HEADER);
		chk("ept_reason", er, r);
		rdy = 1;
		tk(1);
		chk("ept_drop", ev, 1'b0);
		rdy = 0;
	endtask : ept
	task s_reset;
		chk("limit", lim, FIXED_LIMIT_MA);
		chk("tracking", trk, 1'b0);
		chk("rect", rect, WRS_RECT_DIODE);
		chk("regulator", ren, 1'b1);
		chk("strobe", strb, 1'b1);
	endtask : s_reset
	task s_limit;
		logic [11:0] c [4];
		logic [11:0] e [4];
		logic [3:0] t;
		c = '{12'h0C8, 12'h1F4, 12'h12C, 12'h12D};
		e = '{12'h190, 12'h226, 12'h190, 12'h15F};
		t = 4'b1010;
		mv = 1;
		for (int i = 0; i < 4; i++) begin
			cur = c[i];
			tk(1);
			chk("limit", lim, e[i]);
			chk("tracking", trk, {11'h000, t[i]});
		end
		mv = 0;
		pkt = 1;
		tk(1);
		chk("limit_on", la, 1'b1);
		pkt = 0;
		tk(1);
		chk("limit_off", la, 1'b0);
	endtask : s_limit
	task s_rect;
		uvlo = 1;
		tk(5);
		chk("rect_half", rect, WRS_RECT_HALF);
		meas(12'h259);
		chk("rect_full", rect, WRS_RECT_FULL);
		meas(12'h230);
		chk("rect_hold", rect, WRS_RECT_FULL);
		meas(12'h1F3);
		chk("rect_back", rect, WRS_RECT_HALF);
		ent = 12'h1F4;
		meas(12'h1F5);
		chk("rect_entry", rect, WRS_RECT_FULL);
	endtask : s_rect
	task s_temp;
		prio = 1;
		hot = 1;
		for (int i = 0; i < 400 && s_hot !== 1'b1; i++)
			tk(1);
		chk("hot", s_hot, 1'b1);
		ept(EPT_OVERTEMP);
		hot = 0;
		cold = 1;
		for (int i = 0; i < 400 && s_cold !== 1'b1; i++)
			tk(1);
		chk("cold", s_cold, 1'b1);
		cold = 0;
		prio = 0;
	endtask : s_temp
	task s_done;
		rq_d = 1;
		tk(1);
		chk("done_line", pin.done_line, 1'b0);
		for (int i = 0; i < 400 && c1 !== 1'b1; i++)
			tk(1);
		chk("ctrl_one", c1, 1'b1);
		chk("float", pin.bias_oe_n, 1'b1);
		chk("strobe_off", strb, 1'b0);
		chk("charge_done", cd, 1'b1);
		chk("reg_done", ren, 1'b0);
		ept(EPT_CHARGE_DONE);
		rq_d = 0;
	endtask : s_done
	task s_fault;
		rq_f = 1;
		rq_d = 1;
		tk(1);
		chk("fault_line", pin.fault_line, 1'b1);
		chk("done_kept", pin.done_line, 1'b1);
		for (int i = 0; i < 400 && fi !== 1'b1; i++)
			tk(1);
		chk("fault", fi, 1'b1);
		chk("reg_fault", ren, 1'b0);
		ept(EPT_OVERTEMP);
		rq_f = 0;
		rq_d = 0;
	endtask : s_fault
	task s_die;
		die_sd = 1;
		tk(4);
		chk("reg_off", ren, 1'b0);
		ept(EPT_INTERNAL_FAULT);
		die_sd = 0;
		tk(4);
		chk("reg_wait", ren, 1'b0);
		die_hy = 1;
		tk(4);
		chk("reg_on", ren, 1'b1);
		die_hy = 0;
	endtask : s_die
	initial begin
		#500000;
		n_mismatch++;
		close_out;
	end
	initial begin
		do_rst;
		s_reset;
		s_limit;
		s_rect;
		s_temp;
		do_rst;
		s_done;
		do_rst;
		s_fault;
		do_rst;
		s_die;
		close_out;
	end
endmodule : wireless_rx_supervisor_test
